// >>> rtl/pric_pkg.sv
// constants, register map and state encoding of the prioritized interrupt controller
package pric_pkg;
  localparam int NSRC = 45;
  localparam int NFLAG = 48;
  localparam int NPRI_REG = 12;
  localparam int NTRAP = 4;
  localparam int AW = 5;
  localparam int DW = 16;
  localparam int HOLD_W = 14;

  // register word addresses
  localparam logic [4:0] ADDR_FLAGS0 = 5'h00;
  localparam logic [4:0] ADDR_ENABLES0 = 5'h03;
  localparam logic [4:0] ADDR_PRIO0 = 5'h06;
  localparam logic [4:0] ADDR_EXC_CTRL = 5'h12;
  localparam logic [4:0] ADDR_GLOBAL_CTRL = 5'h13;
  localparam logic [4:0] ADDR_PEND_VEC = 5'h14;
  localparam logic [4:0] ADDR_CPU_PRI = 5'h15;

  // field positions
  localparam int NO_NEST_BIT = 15;
  localparam int ALT_TABLE_BIT = 15;
  localparam int HOLD_STAT_BIT = 14;
  localparam int VEC_NUM_LSB = 0;
  localparam int NEW_LEVEL_LSB = 8;

  // reset values
  localparam logic [15:0] RST_REG = 16'h0000;
  localparam logic [3:0] RST_CPU_PRI = 4'h0;

  // vector geometry in program memory
  localparam logic [23:0] PRIMARY_TABLE_BASE = 24'h000004;
  localparam logic [23:0] ALTERNATE_TABLE_BASE = 24'h000084;
  localparam logic [23:0] VECTOR_SPACE_FIRST = 24'h000004;
  localparam logic [23:0] VECTOR_SPACE_LAST = 24'h0000fe;
  localparam logic [5:0] SRC_VEC_OFFSET = 6'h08;

  // levels
  localparam logic [3:0] LVL_HOLD_MAX = 4'h6;
  localparam logic [3:0] TRAP_LEVEL [NTRAP] = '{4'hb, 4'hc, 4'hd, 4'he};
  localparam logic [5:0] TRAP_VEC [NTRAP] = '{6'h03, 6'h04, 6'h05, 6'h06};
  localparam int TRAP_ADDR_ERR = 1;

  // external request inputs with selectable edge
  localparam int NEXT = 5;
  localparam int EXT_SRC [NEXT] = '{0, 16, 23, 36, 37};

  typedef enum logic [1:0] {
    PRIC_IDLE = 2'b00,
    PRIC_REQ = 2'b01,
    PRIC_FETCH = 2'b11,
    PRIC_LOAD = 2'b10
  } pric_state_type;
endpackage

// >>> rtl/pric_top.sv
// prioritized interrupt controller: flags, enables, arbitration and vector entry
//
// The strobed register port and the placing of the registers were decided locally.
`timescale 1ns/1ns
// Functional notes
// - arbitrate 45 sources plus four exceptions in one priority scheme.
// - program counter loaded with 24-bit vector word read from program memory.
// - vector tables start near program memory start, first vector at 0x000004.
// - flags set by sources; only software writes clear them.
// - flags set even when the source enable is clear.
// - pending flag interrupts only while its enable bit is set.
// - 3-bit priority in low bits of each nibble; nibble top bit reads zero.
// - levels 1 to 7 assignable, 7 highest, 1 lowest.
// - priority zero means the source is never taken.
// - cpu priority is 4 bits: top bit core control, low three status.
// - winning vector number and level latched into a readable register.
// - no-nesting bit blocks new source interrupts while one is serviced; exceptions are still taken.
// - while no-nesting is set cpu priority ignores writes.
// - hold blocks levels 6 and below for counted instructions; status bit set.
// - 63 vectors of 24 bits between 0x000004 and 0x0000fe.
// - normal fetch from vector space raises the address error exception.
// - equal priority: lowest natural position wins.
// - natural rank equals source number; vector is source number plus 8.
// - first control register holds exception bits, second external edge and table.
// - sample at instruction start; enabled request above cpu priority interrupts.
// - on entry core stacks pc and status byte; new level masks lower ones.
// - exceptions use levels 11 to 14, so top cpu priority bit marks them.
module pric_top
  import pric_pkg::*;
(
  input wire logic ref_clk, // 10 MHz clock
  input wire logic rst, // synchronous reset, active high
  input wire logic [AW-1:0] reg_addr, // register word address
  input wire logic [DW-1:0] reg_wdata, // register write data
  input wire logic reg_wr, // write strobe
  input wire logic reg_rd, // read strobe
  output logic [DW-1:0] reg_rdata, // read data, cycle after strobe
  input wire logic [NSRC-1:0] src_event, // peripheral and pin requests
  input wire logic [NTRAP-1:0] trap_event, // core exception pulses
  input wire logic instr_tick, // start of instruction cycle
  input wire logic hold_start, // low priority hold instruction executed
  input wire logic [HOLD_W-1:0] hold_count, // instructions to hold
  input wire logic [23:0] fetch_addr, // core instruction fetch address
  input wire logic fetch_valid, // normal instruction fetch this cycle
  output logic irq_req, // interrupt request to core
  output logic [5:0] irq_vec_num, // vector number of request
  output logic [3:0] irq_level, // level of request
  input wire logic irq_ack, // core accepts the request
  output logic stack_push, // core stacks pc and status low byte
  output logic vec_rd, // vector word read strobe
  output logic [23:0] vec_rd_addr, // vector location in program memory
  input wire logic [23:0] vector_word, // vector word, cycle after vec_rd
  output logic pc_load, // load program counter pulse
  output logic [23:0] pc_load_value, // new program counter
  input wire logic irq_return, // return from interrupt
  input wire logic [3:0] return_level, // unstacked cpu priority
  output logic [3:0] cpu_priority // current cpu priority
);
  pric_state_type state_q;
  logic [NSRC-1:0] sync1_q, sync2_q, sync3_q;
  logic [NFLAG-1:0] flag_q, flag_d, en_q;
  logic [2:0] pri_q [NSRC];
  logic [NTRAP-1:0] trap_flag_q;
  logic no_nest_q, alt_table_q;
  logic [NEXT-1:0] ext_neg_q;
  logic [3:0] cpu_pri_q;
  logic [3:0] depth_q;
  logic [HOLD_W-1:0] hold_cnt_q;
  logic [5:0] pend_vec_q;
  logic [3:0] pend_lvl_q;
  logic [5:0] req_vec_q;
  logic [3:0] req_lvl_q;
  logic [23:0] vec_addr_q;
  logic [23:0] pc_val_q;
  logic pc_load_q, push_q;
  logic [DW-1:0] rdata_q;
  logic [NSRC-1:0] neg_sel, edge_hit;
  logic hold_active, vec_space_hit;
  logic win_valid;
  logic [5:0] win_vec;
  logic [3:0] win_lvl;
  logic [NFLAG-1:0] flag_wmask;
  logic [NTRAP-1:0] trap_d;

  // pin and peripheral requests pass two flops; third flop feeds edge detect
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end else begin
      sync1_q <= src_event;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  always_comb begin
    neg_sel = '0;
    for (int e = 0; e < NEXT; e++) begin
      neg_sel[EXT_SRC[e]] = ext_neg_q[e];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NSRC; g++) begin : g_edge
      assign edge_hit[g] = neg_sel[g] ? (sync3_q[g] & ~sync2_q[g])
                                      : (sync2_q[g] & ~sync3_q[g]);
    end
  endgenerate

  // request flags: software write replaces, a new event wins over a clear
  always_comb begin
    flag_wmask = '0;
    flag_wmask[NSRC-1:0] = '1;
    flag_d = flag_q;
    for (int r = 0; r < 3; r++) begin
      if (reg_wr && reg_addr == ADDR_FLAGS0 + 5'(r)) begin
        flag_d[r*16 +: 16] = reg_wdata;
      end
    end
    flag_d[NSRC-1:0] = flag_d[NSRC-1:0] | edge_hit;
    flag_d = flag_d & flag_wmask;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flag_q <= '0;
    end else begin
      flag_q <= flag_d;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      en_q <= '0;
    end else begin
      for (int r = 0; r < 3; r++) begin
        if (reg_wr && reg_addr == ADDR_ENABLES0 + 5'(r)) begin
          en_q[r*16 +: 16] <= reg_wdata & flag_wmask[r*16 +: 16];
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      for (int i = 0; i < NSRC; i++) begin
        pri_q[i] <= 3'h0;
      end
    end else begin
      for (int i = 0; i < NSRC; i++) begin
        if (reg_wr && reg_addr == ADDR_PRIO0 + 5'(i / 4)) begin
          pri_q[i] <= reg_wdata[(i % 4) * 4 +: 3];
        end
      end
    end
  end

  // vector space guard on normal fetches
  assign vec_space_hit = fetch_valid && fetch_addr >= VECTOR_SPACE_FIRST &&
                         fetch_addr <= VECTOR_SPACE_LAST;

  always_comb begin
    trap_d = trap_flag_q;
    if (reg_wr && reg_addr == ADDR_EXC_CTRL) begin
      trap_d = reg_wdata[NTRAP-1:0];
    end
    trap_d = trap_d | trap_event;
    trap_d[TRAP_ADDR_ERR] = trap_d[TRAP_ADDR_ERR] | vec_space_hit;
  end

  // exception control and global control registers
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trap_flag_q <= '0;
      no_nest_q <= 1'b0;
      alt_table_q <= 1'b0;
      ext_neg_q <= '0;
    end else begin
      trap_flag_q <= trap_d;
      if (reg_wr && reg_addr == ADDR_EXC_CTRL) begin
        no_nest_q <= reg_wdata[NO_NEST_BIT];
      end
      if (reg_wr && reg_addr == ADDR_GLOBAL_CTRL) begin
        alt_table_q <= reg_wdata[ALT_TABLE_BIT];
        ext_neg_q <= reg_wdata[NEXT-1:0];
      end
    end
  end

  // low priority hold counts instruction cycles
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      hold_cnt_q <= '0;
    end else if (hold_start) begin
      hold_cnt_q <= hold_count;
    end else if (instr_tick && hold_cnt_q != '0) begin
      hold_cnt_q <= hold_cnt_q - 1'b1;
    end
  end

  assign hold_active = hold_cnt_q != '0;

  // arbitration: exceptions first, then user level, then natural order
  always_comb begin
    win_valid = 1'b0;
    win_vec = 6'h00;
    win_lvl = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (flag_q[i] && en_q[i] && pri_q[i] != 3'h0 &&
          {1'b0, pri_q[i]} > cpu_pri_q &&
          !(hold_active && {1'b0, pri_q[i]} <= LVL_HOLD_MAX) &&
          (!win_valid || {1'b0, pri_q[i]} >= win_lvl)) begin
        win_valid = 1'b1;
        win_vec = 6'(i) + SRC_VEC_OFFSET;
        win_lvl = {1'b0, pri_q[i]};
      end
    end
    if (no_nest_q && depth_q != 4'h0) begin
      win_valid = 1'b0;
    end
    for (int t = 0; t < NTRAP; t++) begin
      if (trap_flag_q[t] && TRAP_LEVEL[t] > cpu_pri_q &&
          (TRAP_LEVEL[t] >= win_lvl || !win_valid)) begin
        win_valid = 1'b1;
        win_vec = TRAP_VEC[t];
        win_lvl = TRAP_LEVEL[t];
      end
    end
  end

  // entry sequence towards the core
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_q <= PRIC_IDLE;
    end else begin
      case (state_q)
        PRIC_IDLE: begin
          if (instr_tick && win_valid) begin
            state_q <= PRIC_REQ;
          end
        end
        PRIC_REQ: begin
          if (irq_ack) begin
            state_q <= PRIC_FETCH;
          end
        end
        PRIC_FETCH: begin
          state_q <= PRIC_LOAD;
        end
        PRIC_LOAD: begin
          state_q <= PRIC_IDLE;
        end
        default: begin
          state_q <= PRIC_IDLE;
        end
      endcase
    end
  end

  // winner latched at the start of an instruction cycle
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pend_vec_q <= 6'h00;
      pend_lvl_q <= 4'h0;
      req_vec_q <= 6'h00;
      req_lvl_q <= 4'h0;
      vec_addr_q <= '0;
    end else if (state_q == PRIC_IDLE && instr_tick && win_valid) begin
      pend_vec_q <= win_vec;
      pend_lvl_q <= win_lvl;
      req_vec_q <= win_vec;
      req_lvl_q <= win_lvl;
      vec_addr_q <= (alt_table_q ? ALTERNATE_TABLE_BASE : PRIMARY_TABLE_BASE)
                    + {17'h00000, win_vec, 1'b0};
    end
  end

  // cpu priority and nesting depth
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      cpu_pri_q <= RST_CPU_PRI;
      depth_q <= 4'h0;
    end else if (state_q == PRIC_REQ && irq_ack) begin
      cpu_pri_q <= req_lvl_q;
      // saturate so a deep trap chain cannot wrap and reopen nesting
      if (depth_q != 4'hf) begin
        depth_q <= depth_q + 4'h1;
      end
    end else if (irq_return) begin
      cpu_pri_q <= return_level;
      if (depth_q != 4'h0) begin
        depth_q <= depth_q - 4'h1;
      end
    end else if (reg_wr && reg_addr == ADDR_CPU_PRI && !no_nest_q) begin
      cpu_pri_q <= reg_wdata[3:0];
    end
  end

  // stack push, vector fetch and program counter load
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      push_q <= 1'b0;
      pc_load_q <= 1'b0;
      pc_val_q <= '0;
    end else begin
      push_q <= state_q == PRIC_REQ && irq_ack;
      pc_load_q <= state_q == PRIC_LOAD;
      if (state_q == PRIC_LOAD) begin
        pc_val_q <= vector_word;
      end
    end
  end

  // register read port, data in the cycle after the strobe
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= RST_REG;
    end else if (reg_rd) begin
      rdata_q <= 16'h0000;
      if (reg_addr >= ADDR_FLAGS0 && reg_addr < ADDR_ENABLES0) begin
        rdata_q <= flag_q[(reg_addr - ADDR_FLAGS0) * 16 +: 16];
      end else if (reg_addr >= ADDR_ENABLES0 && reg_addr < ADDR_PRIO0) begin
        rdata_q <= en_q[(reg_addr - ADDR_ENABLES0) * 16 +: 16];
      end else if (reg_addr >= ADDR_PRIO0 && reg_addr < ADDR_PRIO0 + 5'(NPRI_REG)) begin
        for (int i = 0; i < NSRC; i++) begin
          if (reg_addr == ADDR_PRIO0 + 5'(i / 4)) begin
            rdata_q[(i % 4) * 4 +: 4] <= {1'b0, pri_q[i]};
          end
        end
      end else if (reg_addr == ADDR_EXC_CTRL) begin
        rdata_q <= {no_nest_q, 11'h000, trap_flag_q};
      end else if (reg_addr == ADDR_GLOBAL_CTRL) begin
        rdata_q <= {alt_table_q, hold_active, 9'h000, ext_neg_q};
      end else if (reg_addr == ADDR_PEND_VEC) begin
        rdata_q <= {4'h0, pend_lvl_q, 2'h0, pend_vec_q};
      end else if (reg_addr == ADDR_CPU_PRI) begin
        rdata_q <= {12'h000, cpu_pri_q};
      end
    end
  end

  assign reg_rdata = rdata_q;
  assign irq_req = state_q == PRIC_REQ;
  assign irq_vec_num = req_vec_q;
  assign irq_level = req_lvl_q;
  assign stack_push = push_q;
  assign vec_rd = state_q == PRIC_FETCH;
  assign vec_rd_addr = vec_addr_q;
  assign pc_load = pc_load_q;
  assign pc_load_value = pc_val_q;
  assign cpu_priority = cpu_pri_q;
endmodule

// >>> tb/pric_properties.sv
// concurrent checks on the interrupt controller ports
`timescale 1ns/1ns
module pric_properties
  import pric_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rst, // reset
  input wire logic [AW-1:0] reg_addr, // address
  input wire logic reg_rd, // read strobe
  input wire logic [DW-1:0] reg_rdata, // read data
  input wire logic irq_req, // request
  input wire logic [5:0] irq_vec_num, // vector number
  input wire logic [3:0] irq_level, // level
  input wire logic irq_ack, // accept
  input wire logic stack_push, // stack strobe
  input wire logic vec_rd, // vector read
  input wire logic [23:0] vec_rd_addr, // vector address
  input wire logic [23:0] vector_word, // vector word
  input wire logic pc_load, // pc load
  input wire logic [23:0] pc_load_value, // pc value
  input wire logic [3:0] cpu_priority // cpu priority
);
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  sequence s_entry;
    vec_rd && stack_push;
  endsequence
  sequence s_load;
    !vec_rd ##1 pc_load;
  endsequence
  AST_REQ_HOLD: assert property (irq_req && !irq_ack |=> irq_req && $stable(irq_vec_num)
    && $stable(irq_level)) else $error("request dropped or changed before accept");
  AST_ENTRY_SEQ: assert property (irq_req && irq_ack |=> s_entry ##1 s_load)
    else $error("entry sequence out of order");
  AST_VEC_ADDR: assert property (vec_rd |->
    vec_rd_addr == PRIMARY_TABLE_BASE + {$past(irq_vec_num), 1'b0}
    || vec_rd_addr == ALTERNATE_TABLE_BASE + {$past(irq_vec_num), 1'b0})
    else $error("vector location wrong");
  AST_NEW_LEVEL: assert property (irq_req && irq_ack |=> cpu_priority == $past(irq_level))
    else $error("cpu priority not loaded");
  AST_PC_WORD: assert property (pc_load |-> pc_load_value == $past(vector_word))
    else $error("pc not loaded with vector word");
  AST_ABOVE_CPU: assert property ($rose(irq_req) |-> irq_level > cpu_priority)
    else $error("request not above cpu priority");
  AST_LEVEL_CLASS: assert property (irq_req |-> irq_level[3] == (irq_vec_num < SRC_VEC_OFFSET))
    else $error("level class and vector disagree");
  AST_CPU_READ: assert property (reg_rd && reg_addr == ADDR_CPU_PRI |=>
    reg_rdata == {12'h000, $past(cpu_priority)}) else $error("cpu priority read wrong");
  AST_NIBBLE_TOP: assert property (reg_rd && reg_addr >= ADDR_PRIO0 && reg_addr < ADDR_EXC_CTRL
    |=> (reg_rdata & 16'h8888) == 16'h0000) else $error("nibble top bit set");
  AST_UNMAPPED: assert property (reg_rd && reg_addr > ADDR_CPU_PRI |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
endmodule

// >>> tb/pric_core_model.sv
// behavioural core: accepts requests and serves vector words
`timescale 1ns/1ns
module pric_core_model (
  input wire logic ref_clk, // clock
  input wire logic rst, // reset
  input wire logic irq_req, // request from controller
  input wire logic vec_rd, // vector read strobe
  input wire logic [23:0] vec_rd_addr, // vector location
  input wire logic [3:0] ack_delay, // cycles before accepting
  output logic irq_ack, // accept pulse
  output logic [23:0] vector_word // memory data
);
  logic [3:0] wait_q;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wait_q <= 4'h0;
      irq_ack <= 1'b0;
    end else if (irq_ack) begin
      wait_q <= 4'h0;
      irq_ack <= 1'b0;
    end else if (irq_req) begin
      if (wait_q >= ack_delay) begin
        irq_ack <= 1'b1;
      end else begin
        wait_q <= wait_q + 4'h1;
      end
    end
  end
  // word stands one cycle after the strobe, scrambled otherwise
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      vector_word <= 24'h000000;
    end else if (vec_rd) begin
      vector_word <= 24'h100000 | vec_rd_addr;
    end else begin
      vector_word <= ~vector_word;
    end
  end
endmodule

// >>> tb/pric_tb_top.sv
// self-checking testbench of the prioritized interrupt controller
`timescale 1ns/1ns
module pric_tb_top
  import pric_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [AW-1:0] reg_addr = 5'h00;
  logic [DW-1:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [NSRC-1:0] src_event = '0;
  logic [NTRAP-1:0] trap_event = 4'h0;
  logic instr_tick = 1'b0;
  logic hold_start = 1'b0;
  logic [HOLD_W-1:0] hold_count = 14'h0000;
  logic [23:0] fetch_addr = 24'h000200;
  logic fetch_valid = 1'b0;
  logic irq_return = 1'b0;
  logic [3:0] return_level = 4'h0;
  logic [3:0] ack_delay = 4'h0;
  logic [23:0] tbl_base = PRIMARY_TABLE_BASE;
  logic [DW-1:0] reg_rdata;
  logic irq_req, irq_ack, stack_push, vec_rd, pc_load;
  logic [5:0] irq_vec_num;
  logic [3:0] irq_level, cpu_priority;
  logic [23:0] vec_rd_addr, vector_word, pc_load_value;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  pric_top u_dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_event(src_event),
    .trap_event(trap_event), .instr_tick(instr_tick), .hold_start(hold_start),
    .hold_count(hold_count), .fetch_addr(fetch_addr), .fetch_valid(fetch_valid),
    .irq_req(irq_req), .irq_vec_num(irq_vec_num), .irq_level(irq_level), .irq_ack(irq_ack),
    .stack_push(stack_push), .vec_rd(vec_rd), .vec_rd_addr(vec_rd_addr),
    .vector_word(vector_word), .pc_load(pc_load), .pc_load_value(pc_load_value),
    .irq_return(irq_return), .return_level(return_level), .cpu_priority(cpu_priority));
  pric_core_model u_core (.ref_clk(ref_clk), .rst(rst), .irq_req(irq_req), .vec_rd(vec_rd),
    .vec_rd_addr(vec_rd_addr), .ack_delay(ack_delay), .irq_ack(irq_ack),
    .vector_word(vector_word));
  task stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      stop_test;
    end
  end
  task check(input logic [23:0] seen, input logic [23:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task rdc(input logic [4:0] a, input logic [15:0] exp);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, exp);
  endtask
  task tick;
    @(posedge ref_clk);
    instr_tick <= 1'b1;
    @(posedge ref_clk);
    instr_tick <= 1'b0;
  endtask
  task quiet;
    tick;
    repeat (3) @(posedge ref_clk);
    #1;
    check(irq_req, 1'b0);
  endtask
  // synchronised sources need a few cycles to land in the flags
  task raise(input logic [NSRC-1:0] m);
    @(posedge ref_clk);
    src_event <= m;
    repeat (4) @(posedge ref_clk);
    src_event <= '0;
    repeat (4) @(posedge ref_clk);
  endtask
  task ret;
    @(posedge ref_clk);
    irq_return <= 1'b1;
    return_level <= 4'h0;
    @(posedge ref_clk);
    irq_return <= 1'b0;
  endtask
  task service(input logic [5:0] v, input logic [3:0] l);
    int i;
    tick;
    #1;
    for (i = 0; i < 20 && irq_req !== 1'b1; i++) @(posedge ref_clk) #1;
    check(irq_vec_num, v);
    check(irq_level, l);
    for (i = 0; i < 40 && pc_load !== 1'b1; i++) @(posedge ref_clk) #1;
    check(pc_load_value, 24'h100000 | (tbl_base + {v, 1'b0}));
    check(cpu_priority, l);
  endtask
  task t_regs;
    rdc(ADDR_FLAGS0, RST_REG);
    rdc(ADDR_CPU_PRI, 16'h0000);
    rdc(ADDR_PEND_VEC, 16'h0000);
    wr(ADDR_PRIO0, 16'hffff);
    rdc(ADDR_PRIO0, 16'h7777);
    wr(5'h11, 16'hffff);
    rdc(5'h11, 16'h0007);
    wr(5'h05, 16'hffff);
    rdc(5'h05, 16'h1fff);
    wr(5'h1f, 16'hffff);
    rdc(5'h1f, 16'h0000);
    wr(5'h11, 16'h0000);
    wr(5'h05, 16'h0000);
    $display("t_regs done");
  endtask
  task t_flags;
    wr(ADDR_PRIO0, 16'h5000);
    raise(45'h8);
    quiet;
    rdc(ADDR_FLAGS0, 16'h0008);
    wr(ADDR_FLAGS0, 16'h0000);
    rdc(ADDR_FLAGS0, 16'h0000);
    wr(ADDR_ENABLES0, 16'h0008);
    raise(45'h8);
    service(6'd11, 4'h5);
    rdc(ADDR_PEND_VEC, 16'h050b);
    rdc(ADDR_FLAGS0, 16'h0008);
    wr(ADDR_FLAGS0, 16'h0000);
    ret;
    $display("t_flags done");
  endtask
  task t_order;
    wr(ADDR_PRIO0, 16'h0330);
    wr(ADDR_ENABLES0, 16'h0006);
    wr(5'h05, 16'h0100);
    raise(45'h10000000006);
    service(6'd9, 4'h3);
    wr(ADDR_FLAGS0, 16'h0004);
    ret;
    service(6'd10, 4'h3);
    wr(ADDR_FLAGS0, 16'h0000);
    ret;
    quiet;
    wr(5'h02, 16'h0000);
    wr(5'h05, 16'h0000);
    $display("t_order done");
  endtask
  task t_hold;
    wr(5'h07, 16'h0060);
    wr(ADDR_ENABLES0, 16'h0020);
    @(posedge ref_clk);
    hold_start <= 1'b1;
    hold_count <= 14'h0002;
    @(posedge ref_clk);
    hold_start <= 1'b0;
    rdc(ADDR_GLOBAL_CTRL, 16'h4000);
    raise(45'h20);
    quiet;
    tick;
    service(6'd13, 4'h6);
    rdc(ADDR_GLOBAL_CTRL, 16'h0000);
    wr(ADDR_FLAGS0, 16'h0000);
    ret;
    $display("t_hold done");
  endtask
  task t_traps;
    int i;
    @(posedge ref_clk);
    fetch_addr <= VECTOR_SPACE_LAST;
    fetch_valid <= 1'b1;
    @(posedge ref_clk);
    fetch_valid <= 1'b0;
    fetch_addr <= 24'h000200;
    service(TRAP_VEC[TRAP_ADDR_ERR], TRAP_LEVEL[TRAP_ADDR_ERR]);
    rdc(ADDR_EXC_CTRL, 16'h0002);
    wr(ADDR_EXC_CTRL, 16'h0000);
    ret;
    for (i = 0; i < NTRAP; i++) begin
      @(posedge ref_clk);
      trap_event <= 4'h1 << i;
      @(posedge ref_clk);
      trap_event <= 4'h0;
      service(TRAP_VEC[i], TRAP_LEVEL[i]);
      wr(ADDR_EXC_CTRL, 16'h0000);
      ret;
    end
    $display("t_traps done");
  endtask
  task t_nest;
    ack_delay <= 4'h5;
    wr(ADDR_EXC_CTRL, 16'h8000);
    wr(ADDR_PRIO0, 16'h5000);
    wr(5'h07, 16'h0007);
    wr(ADDR_ENABLES0, 16'h0018);
    raise(45'h8);
    service(6'd11, 4'h5);
    raise(45'h10);
    quiet;
    wr(ADDR_CPU_PRI, 16'h0000);
    rdc(ADDR_CPU_PRI, 16'h0005);
    wr(ADDR_FLAGS0, 16'h0000);
    ret;
    wr(ADDR_EXC_CTRL, 16'h0000);
    $display("t_nest done");
  endtask
  // alternate table and falling edge select on source 0
  task t_modes;
    wr(ADDR_GLOBAL_CTRL, 16'h8001);
    wr(ADDR_PRIO0, 16'h0004);
    wr(ADDR_ENABLES0, 16'h0001);
    tbl_base = ALTERNATE_TABLE_BASE;
    @(posedge ref_clk);
    src_event <= 45'h1;
    repeat (4) @(posedge ref_clk);
    rdc(ADDR_FLAGS0, 16'h0000);
    src_event <= '0;
    repeat (4) @(posedge ref_clk);
    rdc(ADDR_FLAGS0, 16'h0001);
    service(6'd8, 4'h4);
    wr(ADDR_FLAGS0, 16'h0000);
    ret;
    wr(ADDR_GLOBAL_CTRL, 16'h0000);
    tbl_base = PRIMARY_TABLE_BASE;
    $display("t_modes done");
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    t_regs;
    t_flags;
    t_order;
    t_hold;
    t_traps;
    t_nest;
    t_modes;
    stop_test;
  end
endmodule
bind pric_top pric_properties u_props (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_req(irq_req), .irq_vec_num(irq_vec_num),
  .irq_level(irq_level), .irq_ack(irq_ack), .stack_push(stack_push), .vec_rd(vec_rd),
  .vec_rd_addr(vec_rd_addr), .vector_word(vector_word), .pc_load(pc_load),
  .pc_load_value(pc_load_value), .cpu_priority(cpu_priority));
